//--- dv/backlight_dimming_fault_ctrl_test.sv
`default_nettype none

module backlight_dimming_fault_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int PER = 200;

	logic                      clk;
	logic                      rst;
	backlight_pkg::reg_req_t   req;
	logic                [7:0] rdata;
	backlight_pkg::front_end_t fe;
	logic                [8:0] ext_high;
	logic                      ext;
	logic                      pwm;
	logic                      gate;
	logic                      fault;
	int                        fails;
	int                        compares;

	backlight_dimming_fault_ctrl #(
		.BURST_PERIOD(PER),
		.FAULT_CYCLES(50)
	) u_backlight_dimming_fault_ctrl (
		.CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
		.FRONT_END(fe), .EXT_DUTY_IN(ext), .BURST_PWM(pwm),
		.HS_GATE(gate), .FAULT(fault)
	);

	ext_duty_source u_ext_duty_source (
		.clk(clk), .high(ext_high), .duty_out(ext)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic summarize;
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
		check(16'(rdata), 16'(exp));
	endtask : rd_chk

	// on cycles in one burst period for a brightness code
	task automatic meas(input int code, input int tol);
		int n;
		int exp;
		n = 0;
		exp = PER * 1015 / 10000 + (PER - PER * 1015 / 10000) * code / 255;
		repeat (3 * PER) @(negedge clk);
		repeat (PER) begin
			@(negedge clk);
			if (pwm === 1'b1) n++;
		end
		if (n >= exp - tol && n <= exp + tol) n = exp;
		check(16'(n), 16'(exp));
	endtask : meas

	task automatic mode(input backlight_pkg::mode_t m);
		wr(8'h01, {4'h0, 3'(m), 1'b1});
	endtask : mode

	// lets two duty windows of the external input pass
	task automatic settle;
		repeat (9000) @(negedge clk);
	endtask : settle

	task automatic t_defaults;
		rd_chk(8'h00, 8'hFF);
		rd_chk(8'h01, 8'h01);
		wr(8'h04, 8'h5A);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h07, 8'h00);
	endtask : t_defaults

	task automatic t_register;
		logic [7:0] codes [3] = '{8'h00, 8'h80, 8'hFF};
		foreach (codes[i]) begin
			wr(8'h00, codes[i]);
			meas(codes[i], 0);
		end
	endtask : t_register

	task automatic t_ambient;
		mode(backlight_pkg::MODE_AMBIENT);
		fe.light = 8'h80;
		meas(8'h80, 0);
		rd_chk(8'h04, 8'h80);
		fe.light = 8'h00;
		wr(8'h02, 8'h05);
		meas(8'h1A, 0);
		wr(8'h03, 8'h80);
		fe.light = 8'hF0;
		meas(8'h80, 0);
		wr(8'h03, 8'hFF);
	endtask : t_ambient

	task automatic t_external;
		ext_high = 9'h000;
		mode(backlight_pkg::MODE_EXTERNAL);
		settle();
		meas(8'h1A, 0);
		ext_high = 9'h100;
		settle();
		meas(8'hFF, 0);
	endtask : t_external

	task automatic t_scaled;
		ext_high = 9'h080;
		wr(8'h00, 8'hFF);
		mode(backlight_pkg::MODE_REGISTER_SCALED);
		settle();
		meas(8'h80, 1);
		fe.light = 8'hFF;
		mode(backlight_pkg::MODE_AMBIENT_SCALED);
		meas(8'h80, 1);
		mode(backlight_pkg::MODE_REGISTER);
	endtask : t_scaled

	// error level walks to zero, then one gate step per supply code
	task automatic t_switch(input logic [7:0] sup);
		int   n;
		int   slope;
		logic seen;
		slope = int'(backlight_pkg::SLOPE_BASE) + int'(sup[7:3]);
		n = 0;
		seen = 1'b0;
		fe.supply = sup;
		fe.fb_a = 8'h70;
		fe.fb_b = 8'h70;
		repeat (9000) @(negedge clk);
		fe.fb_a = 8'h40;
		repeat (64) begin
			@(negedge clk);
			if (gate !== 1'b0) seen = 1'b1;
		end
		check(16'(seen), 16'h0000);
		fe.fb_b = 8'h40;
		for (int i = 0; i < 100 && gate !== 1'b1; i++) @(negedge clk);
		while (gate === 1'b1 && n < 8) begin
			n++;
			@(negedge clk);
		end
		// error level of one step puts the threshold at 16
		check(16'(n), 16'((16 + slope - 1) / slope));
		fe.supply = 8'h20;
	endtask : t_switch

	task automatic t_fault;
		fe.fb_a = 8'h3B;
		for (int i = 0; i < 200 && fault !== 1'b1; i++) @(negedge clk);
		check(16'(fault), 16'h0001);
		check(16'({pwm, gate}), 16'h0000);
		fe.fb_a = 8'h40;
		wr(8'h01, 8'h00);
		check(16'(fault), 16'h0000);
		repeat (4) @(negedge clk);
		check(16'({pwm, gate}), 16'h0000);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd_chk(8'h01, 8'h01);
		rd_chk(8'h02, 8'h1A);
	endtask : t_fault

	initial begin
		rst = 1'b1;
		req = '0;
		fe = '{fb_a: 8'h40, fb_b: 8'h40, supply: 8'h20,
			light: 8'h00, over_voltage: 1'b0};
		ext_high = 9'h000;
		fails = 0;
		compares = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_defaults();
		t_register();
		t_ambient();
		t_external();
		t_scaled();
		t_switch(8'h20);
		t_switch(8'hF8);
		t_fault();
		summarize();
	end

	initial begin
		#(80_000 * 100);
		fails++;
		summarize();
	end
endmodule : backlight_dimming_fault_ctrl_test

bind backlight_dimming_fault_ctrl backlight_props #(
	.FAULT_CYCLES(FAULT_CYCLES)
) u_backlight_props (
	.CLK(CLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
	.FRONT_END(FRONT_END), .EXT_DUTY_IN(EXT_DUTY_IN),
	.BURST_PWM(BURST_PWM), .HS_GATE(HS_GATE), .FAULT(FAULT)
);

`default_nettype wire

//--- dv/backlight_props.sv
`default_nettype none

module backlight_props #(
	parameter int FAULT_CYCLES = 50
) (
	// clock and reset
	input wire logic                      CLK,
	input wire logic                      RST,
	// register port
	input wire backlight_pkg::reg_req_t   REG_REQ,
	input wire logic                [7:0] REG_RDATA,
	// front end
	input wire backlight_pkg::front_end_t FRONT_END,
	input wire logic                      EXT_DUTY_IN,
	// drive and fault
	input wire logic                      BURST_PWM,
	input wire logic                      HS_GATE,
	input wire logic                      FAULT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	logic lamp_low;
	logic ctrl_off;
	int   low_run;
	int   next_low_run;

	assign lamp_low = FRONT_END.fb_a < backlight_pkg::FB_LOW_CODE
		|| FRONT_END.fb_b < backlight_pkg::FB_LOW_CODE;
	assign ctrl_off = REG_REQ.wr && REG_REQ.addr == backlight_pkg::ADDR_CTRL
		&& !REG_REQ.wdata[0];

	// consecutive lamp-low cycles with the burst on
	always_comb begin
		next_low_run = (lamp_low && BURST_PWM && !FAULT) ? low_run + 1 : 0;
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) low_run <= 0;
		else low_run <= next_low_run;
	end

	sequence stopped_s;
		!BURST_PWM && !HS_GATE;
	endsequence
	sequence lamp_was_low_s;
		$past(lamp_low, 2) && $past(lamp_low, 3);
	endsequence

	fault_stop_a: assert property (FAULT |-> stopped_s)
		else $error("drive active during fault");
	fault_time_a: assert property (low_run <= FAULT_CYCLES + 3)
		else $error("fault latch late");
	fault_cause_a: assert property ($rose(FAULT) |-> lamp_was_low_s)
		else $error("fault without low lamp");
	fault_clear_a: assert property (ctrl_off |=> !FAULT)
		else $error("fault not cleared");
	fault_hold_a: assert property (FAULT && !ctrl_off |=> FAULT)
		else $error("fault dropped");
	disable_stop_a: assert property (ctrl_off |-> ##2 stopped_s[*3])
		else $error("drive after disable");
	min_on_a: assert property ($rose(BURST_PWM) |-> BURST_PWM[*8])
		else $error("burst on too short");
	reset_clean_a: assert property ($fell(RST) |-> !FAULT &&
		!BURST_PWM && REG_RDATA == 8'h00) else $error("dirty reset");
endmodule : backlight_props

`default_nettype wire

//--- dv/ext_duty_source.sv
`default_nettype none

module ext_duty_source (
	// clock
	input  wire logic       clk,
	// high cycles per 256-cycle period
	input  wire logic [8:0] high,
	// duty output
	output var  logic       duty_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] cnt = 8'h00;

	initial duty_out = 1'b0;

	// 256 clocks per period keeps the source near 39 kHz
	always @(negedge clk) begin
		cnt <= cnt + 8'h01;
		duty_out <= {1'b0, cnt} < high;
	end
endmodule : ext_duty_source

`default_nettype wire

//--- rtl/backlight_dimming_fault_ctrl.sv
`default_nettype none

module backlight_dimming_fault_ctrl #(
	parameter int BURST_RATE_KOHM = backlight_pkg::BURST_RATE_KOHM,
	parameter int BURST_PERIOD    = int'(64'(backlight_pkg::CLK_HZ)
		* 64'(BURST_RATE_KOHM) / (64'(backlight_pkg::BURST_BASE_HZ)
		* 64'(backlight_pkg::BURST_REF_KOHM))),
	parameter int FAULT_CYCLES    = backlight_pkg::FAULT_CYCLES,
	parameter int SW_CYCLES       = backlight_pkg::SW_CYCLES
) (
	// clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RST,
	// register port
	input  wire backlight_pkg::reg_req_t  REG_REQ,
	output logic                    [7:0] REG_RDATA,
	// analog front end and external duty input
	input  wire backlight_pkg::front_end_t FRONT_END,
	input  wire logic                     EXT_DUTY_IN,
	// lamp drive and fault
	output logic                          BURST_PWM,
	output logic                          HS_GATE,
	output logic                          FAULT
);

	localparam int CNT_W  = $clog2(BURST_PERIOD + 1);
	localparam int FLT_W  = $clog2(FAULT_CYCLES + 1);
	localparam int SW_W   = $clog2(SW_CYCLES + 1);
	localparam longint MIN_ON = 64'(BURST_PERIOD)
		* 64'(backlight_pkg::FLOOR_BP) / 64'(backlight_pkg::FULL_BP);

	// product of two fractions of full scale
	function automatic logic [7:0] scale8(input logic [7:0] a,
		input logic [7:0] b);
		logic [15:0] p;
		p = a * b;
		return 8'((p + 16'd127) / 16'd255);
	endfunction : scale8

	function automatic logic [7:0] clamp8(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] r;
		r = v;
		if (r < lo)
			r = lo;
		if (r > hi)
			r = hi;
		return r;
	endfunction : clamp8

	// brightness code to on cycles, linear from floor to full
	function automatic logic [CNT_W-1:0] on_cycles(input logic [7:0] b);
		longint span;
		span = 64'(BURST_PERIOD) - MIN_ON;
		return CNT_W'(MIN_ON + span * 64'(b) / 64'(255));
	endfunction : on_cycles

	// ---------------- register file ----------------
	logic [7:0] bright;
	logic [7:0] ctrl;
	logic [7:0] als_lo;
	logic [7:0] als_hi;
	logic [7:0] light;
	logic [7:0] next_bright;
	logic [7:0] next_ctrl;
	logic [7:0] next_als_lo;
	logic [7:0] next_als_hi;
	logic [7:0] next_rdata;
	logic       clear_req;

	always_comb begin
		next_bright = bright;
		next_ctrl   = ctrl;
		next_als_lo = als_lo;
		next_als_hi = als_hi;
		next_rdata  = REG_RDATA;
		clear_req   = 1'b0;
		if (REG_REQ.wr) begin
			unique case (REG_REQ.addr)
				backlight_pkg::ADDR_BRIGHT: next_bright = REG_REQ.wdata;
				backlight_pkg::ADDR_CTRL: begin
					next_ctrl = REG_REQ.wdata;
					clear_req = ~REG_REQ.wdata[backlight_pkg::CTRL_EN_BIT];
				end
				backlight_pkg::ADDR_ALS_LO: next_als_lo = REG_REQ.wdata;
				backlight_pkg::ADDR_ALS_HI: next_als_hi = REG_REQ.wdata;
				default: ;
			endcase
		end
		if (REG_REQ.rd) begin
			unique case (REG_REQ.addr)
				backlight_pkg::ADDR_BRIGHT: next_rdata = bright;
				backlight_pkg::ADDR_CTRL:   next_rdata = ctrl;
				backlight_pkg::ADDR_ALS_LO: next_rdata = als_lo;
				backlight_pkg::ADDR_ALS_HI: next_rdata = als_hi;
				backlight_pkg::ADDR_LIGHT:  next_rdata = light;
				default:                    next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bright    <= backlight_pkg::BRIGHT_RST;
			ctrl      <= backlight_pkg::CTRL_RST;
			als_lo    <= backlight_pkg::ALS_LO_RST;
			als_hi    <= backlight_pkg::ALS_HI_RST;
			REG_RDATA <= 8'h00;
		end else begin
			bright    <= next_bright;
			ctrl      <= next_ctrl;
			als_lo    <= next_als_lo;
			als_hi    <= next_als_hi;
			REG_RDATA <= next_rdata;
		end
	end

	// ---------------- brightness source ----------------
	logic [7:0] ext_duty;
	logic [7:0] ext_bright;
	logic [7:0] amb_lo;
	logic [7:0] amb_bright;
	logic [7:0] target;
	backlight_pkg::mode_t mode;

	duty_meter #(
		.WIN_W (backlight_pkg::DUTY_WIN_W)
	) u_duty_meter (
		.clk    (CLK),
		.rst    (RST),
		.pwm_in (EXT_DUTY_IN),
		.duty   (ext_duty)
	);

	always_comb begin
		mode = backlight_pkg::mode_t'(
			ctrl[backlight_pkg::CTRL_MODE_MSB:backlight_pkg::CTRL_MODE_LSB]);
		ext_bright = (ext_duty < backlight_pkg::FLOOR_CODE)
			? backlight_pkg::FLOOR_CODE : ext_duty;
		amb_lo = (als_lo < backlight_pkg::FLOOR_CODE)
			? backlight_pkg::FLOOR_CODE : als_lo;
		amb_bright = clamp8(FRONT_END.light, amb_lo, als_hi);
		unique case (mode)
			backlight_pkg::MODE_REGISTER:
				target = bright;
			backlight_pkg::MODE_EXTERNAL:
				target = ext_bright;
			backlight_pkg::MODE_AMBIENT:
				target = amb_bright;
			backlight_pkg::MODE_AMBIENT_SCALED:
				target = scale8(amb_bright, ext_duty);
			backlight_pkg::MODE_REGISTER_SCALED:
				target = scale8(bright, ext_duty);
			default:
				target = bright;
		endcase
	end

	// ---------------- burst dimming timing ----------------
	logic             fault;
	logic             run;
	logic [CNT_W-1:0] burst_cnt;
	logic [CNT_W-1:0] on_len;
	logic [CNT_W-1:0] next_burst_cnt;
	logic [CNT_W-1:0] next_on_len;
	logic [7:0]       next_light;
	logic             burst_on;
	logic             next_burst_pwm;

	always_comb begin
		run            = ctrl[backlight_pkg::CTRL_EN_BIT] & ~fault;
		next_on_len    = on_len;
		next_light     = light;
		next_burst_cnt = burst_cnt + 1'b1;
		if (burst_cnt == CNT_W'(BURST_PERIOD - 1))
			next_burst_cnt = '0;
		if (burst_cnt == '0) begin
			next_light  = FRONT_END.light;
			next_on_len = on_cycles(target);
		end
		burst_on       = run & (burst_cnt < on_len);
		next_burst_pwm = burst_on & ~next_fault;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			burst_cnt <= '0;
			on_len    <= '0;
			light     <= backlight_pkg::LIGHT_RST;
			BURST_PWM <= 1'b0;
		end else begin
			burst_cnt <= next_burst_cnt;
			on_len    <= next_on_len;
			light     <= next_light;
			BURST_PWM <= next_burst_pwm;
		end
	end

	// ---------------- switching and error level ----------------
	logic [SW_W-1:0] sw_cnt;
	logic [11:0]     ramp;
	logic [7:0]      comp;
	logic [SW_W-1:0] next_sw_cnt;
	logic [11:0]     next_ramp;
	logic [7:0]      next_comp;
	logic            next_hs;
	logic [7:0]      fb_max;
	logic [11:0]     slope;
	logic            timing;

	always_comb begin
		fb_max = (FRONT_END.fb_a > FRONT_END.fb_b)
			? FRONT_END.fb_a : FRONT_END.fb_b;
		slope = backlight_pkg::SLOPE_BASE
			+ 12'(FRONT_END.supply[7:3]);
		next_sw_cnt = sw_cnt + 1'b1;
		next_ramp   = ramp + slope;
		next_comp   = comp;
		if (sw_cnt == SW_W'(SW_CYCLES - 1)) begin
			next_sw_cnt = '0;
			next_ramp   = '0;
			if (!run)
				next_comp = 8'h00;
			else if (FRONT_END.over_voltage && timing)
				next_comp = (comp > backlight_pkg::OVP_STEP)
					? comp - backlight_pkg::OVP_STEP : 8'h00;
			else if (burst_on && fb_max < backlight_pkg::FB_REG_CODE)
				next_comp = (comp == 8'hFF) ? comp : comp + 8'h01;
			else if (burst_on)
				next_comp = (comp == 8'h00) ? comp : comp - 8'h01;
			else
				next_comp = (comp > backlight_pkg::SOFT_STOP_STEP)
					? comp - backlight_pkg::SOFT_STOP_STEP : 8'h00;
		end
		next_hs = run & ~next_fault & (comp != 8'h00)
			& (ramp < {comp, 4'h0});
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sw_cnt  <= '0;
			ramp    <= '0;
			comp    <= 8'h00;
			HS_GATE <= 1'b0;
		end else begin
			sw_cnt  <= next_sw_cnt;
			ramp    <= next_ramp;
			comp    <= next_comp;
			HS_GATE <= next_hs;
		end
	end

	// ---------------- lamp-out fault ----------------
	logic [FLT_W-1:0] flt_cnt;
	logic [FLT_W-1:0] next_flt_cnt;
	logic             next_fault;
	logic             lamp_low;

	always_comb begin
		lamp_low = (FRONT_END.fb_a < backlight_pkg::FB_LOW_CODE)
			| (FRONT_END.fb_b < backlight_pkg::FB_LOW_CODE);
		timing       = burst_on & lamp_low;
		next_flt_cnt = flt_cnt;
		next_fault   = fault;
		if (clear_req)
			next_fault = 1'b0;
		if (!run)
			next_flt_cnt = '0;
		else if (timing) begin
			next_flt_cnt = flt_cnt + 1'b1;
			if (flt_cnt == FLT_W'(FAULT_CYCLES - 1)) begin
				next_fault   = 1'b1;
				next_flt_cnt = '0;
			end
		end else if (burst_on)
			next_flt_cnt = '0;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flt_cnt <= '0;
			fault   <= 1'b0;
			FAULT   <= 1'b0;
		end else begin
			flt_cnt <= next_flt_cnt;
			fault   <= next_fault;
			FAULT   <= next_fault;
		end
	end

endmodule : backlight_dimming_fault_ctrl

`default_nettype wire

//--- rtl/backlight_pkg.sv
// Functional notes
// - error level against ramp sets on-time
// - larger of two feedbacks regulates
// - ramp slope rises with supply voltage
// - dimming duty spans 10.15 percent to full
// - burst rate is 210 Hz times 169k/R
// - soft-start ramp up, linear soft-stop down
// - control bits 3:1 pick one of five modes
// - ambient brightness clamped to low/high limits
// - ambient low limit never below ten percent
// - light code sampled each period, readable
// - 256 brightness levels, fixed step per code
// - external duty sets brightness, ten percent floor
// - register code 0xFF full, brightness_setting minimum
// - ambient brightness scaled by external duty
// - register brightness scaled by external duty
// - low feedback advances the lamp-out timer
// - timer expiry latches fault, stops switching
// - control bit 0 clear or reset clears fault
// - overvoltage during lamp-out delay cuts on-time
// - reset clears fault and register defaults
`default_nettype none

package backlight_pkg;

	// clock and burst timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int BURST_BASE_HZ = 210;
	localparam int BURST_REF_KOHM = 169;
	localparam int BURST_RATE_KOHM = 169;
	localparam int FLOOR_BP      = 1015;
	localparam int FULL_BP       = 10000;
	localparam int SW_CYCLES     = 32;
	localparam int FAULT_CYCLES  = 100_000;
	localparam int DUTY_WIN_W    = 12;

	// register offsets
	localparam logic [7:0] ADDR_BRIGHT = 8'h00;
	localparam logic [7:0] ADDR_CTRL   = 8'h01;
	localparam logic [7:0] ADDR_ALS_LO = 8'h02;
	localparam logic [7:0] ADDR_ALS_HI = 8'h03;
	localparam logic [7:0] ADDR_LIGHT  = 8'h04;

	// control fields
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_MODE_MSB = 3;

	// reset values
	localparam logic [7:0] BRIGHT_RST = 8'hFF;
	localparam logic [7:0] CTRL_RST   = 8'h01;
	localparam logic [7:0] ALS_LO_RST = 8'h1A;
	localparam logic [7:0] ALS_HI_RST = 8'hFF;
	localparam logic [7:0] LIGHT_RST  = 8'h00;

	// brightness codes
	localparam logic [7:0] FLOOR_CODE = 8'h1A;
	localparam logic [7:0] CODE_MAX   = 8'hFF;

	// analog front end scaling, 10 mV per feedback code
	localparam int LAMP_LOW_MV = 600;
	localparam int FB_MV_PER_CODE = 10;
	localparam logic [7:0] FB_LOW_CODE = 8'(LAMP_LOW_MV / FB_MV_PER_CODE);
	localparam logic [7:0] FB_REG_CODE = 8'h64;

	// error level slew, in microamps of the compensation node
	localparam int SOFT_STOP_UA = 110;
	localparam int OVP_UA       = 1000;
	localparam logic [7:0] SOFT_STOP_STEP = 8'h01;
	localparam logic [7:0] OVP_STEP =
		8'((OVP_UA + SOFT_STOP_UA / 2) / SOFT_STOP_UA);

	// ramp feed-forward
	localparam logic [11:0] SLOPE_BASE = 12'h0008;

	typedef enum logic [2:0] {
		MODE_REGISTER,
		MODE_EXTERNAL,
		MODE_AMBIENT,
		MODE_AMBIENT_SCALED,
		MODE_REGISTER_SCALED
	} mode_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] fb_a;
		logic [7:0] fb_b;
		logic [7:0] supply;
		logic [7:0] light;
		logic       over_voltage;
	} front_end_t;

endpackage : backlight_pkg

`default_nettype wire

//--- rtl/duty_meter.sv
`default_nettype none

// measures high fraction of a synchronous pwm over a fixed window
module duty_meter #(
	parameter int WIN_W = 12
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// measured input
	input  wire logic       pwm_in,
	// result, brightness_setting none to 0xFF always high
	output logic      [7:0] duty
);

	logic [WIN_W-1:0] win;
	logic [WIN_W:0]   high;
	logic [WIN_W-1:0] next_win;
	logic [WIN_W:0]   next_high;
	logic [7:0]       next_duty;
	logic [WIN_W:0]   total;

	always_comb begin
		total     = high + (WIN_W+1)'(pwm_in);
		next_win  = win + 1'b1;
		next_high = total;
		next_duty = duty;
		if (&win) begin
			next_high = '0;
			if (total[WIN_W])
				next_duty = 8'hFF;
			else
				next_duty = total[WIN_W-1 -: 8];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			win  <= '0;
			high <= '0;
			duty <= 8'h00;
		end else begin
			win  <= next_win;
			high <= next_high;
			duty <= next_duty;
		end
	end

endmodule : duty_meter

`default_nettype wire
